// file: float_status_map.vh
// Bit positions, codes and reset values of the float status and exception unit
`ifndef FLOAT_STATUS_MAP_VH
`define FLOAT_STATUS_MAP_VH
`define FSW_ERR 15
`define FSW_GDIS 14
`define FSW_RSV_HI 13
`define FSW_RSV_LO 12
`define FSW_UV_EN 11
`define FSW_UF_EN 10
`define FSW_OV_EN 9
`define FSW_CV_EN 8
`define FSW_DBL 7
`define FSW_LONG 6
`define FSW_CHOP 5
`define FSW_MAINT 4
`define FSW_NEG 3
`define FSW_ZERO 2
`define FSW_OVF 1
`define FSW_CARRY 0
`define FSW_WRITE_MASK 16'hcff0
`define FSW_RESET 16'h0000
`define FEC_RESET 4'h0
`define FEA_RESET 16'h0000
`define EXC_OPCODE 4'h2
`define EXC_DIVZERO 4'h4
`define EXC_CONV 4'h6
`define EXC_OVERFLOW 4'h8
`define EXC_UNDERFLOW 4'ha
`define EXC_UNDEFVAR 4'hc
`define EXC_MAINT 4'he
`define FLOAT_VECTOR 9'h0a4
`define EXP_OFFSET 9'h100
`endif

// file: float_status_exception_unit.v
// Float status word, mode bits and exception recording for a floating point processor
`timescale 1ns/1ps
`include "float_status_map.vh"
module float_status_exception_unit (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Status load and read
	input wire loadStatus,
	input wire [15:0] loadData,
	input wire kernelMode,
	output reg [15:0] statusWord_q,
	// Instruction completion from the sequencer
	input wire opDone,
	input wire [15:0] opAddr,
	input wire resNeg,
	input wire resZero,
	input wire resOverflow,
	input wire convCarry,
	// Exception conditions from the sequencer
	input wire excOpcode,
	input wire excDivZero,
	input wire excMaint,
	input wire excOverflow,
	input wire excUnderflow,
	input wire convIsConversion,
	input wire [32:0] convValue,
	input wire operandNegZero,
	input wire operandFromAcc,
	input wire opUsesUndefCheck,
	input wire opUndefAfterExec,
	input wire [8:0] resExponent,
	input wire resultNegZero,
	// Result steering to the datapath
	output reg forceZero_q,
	output reg [7:0] storedExponent_q,
	output reg abortBeforeExec_q,
	// Mode outputs
	output reg doublePrec_q,
	output reg longInt_q,
	output reg chopMode_q,
	output reg maintMode_q,
	// Exception record and interrupt
	output reg [3:0] excCode_q,
	output reg [15:0] excAddr_q,
	output reg irqReq_q,
	output reg [8:0] irqVector_q
);
	// Conversion overflow check against selected width
	function convFails;
		input [32:0] v;
		input isLong;
		begin
			if (isLong)
				convFails = (v[32] != v[31]);
			else
				convFails = (v[32:15] != {18{v[32]}});
		end
	endfunction

	// Result replaced by exact zero on an untrapped overflow or underflow, or on any failed conversion
	function zeroedResult;
		input ovf;
		input ovfEn;
		input udf;
		input udfEn;
		input convFail;
		begin
			zeroedResult = (ovf && !ovfEn) || (udf && !udfEn) || convFail;
		end
	endfunction

	wire gDis = statusWord_q[`FSW_GDIS];
	wire enUv = statusWord_q[`FSW_UV_EN];
	wire enUf = statusWord_q[`FSW_UF_EN];
	wire enOv = statusWord_q[`FSW_OV_EN];
	wire enCv = statusWord_q[`FSW_CV_EN];
	wire convBad = convIsConversion && convFails(convValue, statusWord_q[`FSW_LONG]);
	wire undefHit = opUsesUndefCheck && operandNegZero && !operandFromAcc;
	// Recorded exceptions, unmaskable ones first
	wire recOpc = excOpcode;
	wire recDiv = excDivZero;
	wire recMnt = excMaint && statusWord_q[`FSW_MAINT];
	wire recUv = undefHit && enUv;
	wire recOv = excOverflow && enOv;
	wire recUf = excUnderflow && enUf;
	wire recCv = convBad && enCv;
	wire anyRec = opDone && (recOpc || recDiv || recMnt || recUv || recOv || recUf || recCv);

	// Result steering helpers
	wire zeroRes = zeroedResult(excOverflow, enOv, excUnderflow, enUf, convBad);
	wire [8:0] expOvf = resExponent - `EXP_OFFSET;
	wire [8:0] expUdf = resExponent + `EXP_OFFSET;
	wire irqFire = anyRec && !gDis;

	// Trap sources in priority order, bit 0 first
	wire [6:0] recVec = {recMnt, recUf, recOv, recCv, recUv, recDiv, recOpc};
	wire [6:0] recHigher;
	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1)
		begin : gPrio
			if (g == 0)
			begin : gFirst
				assign recHigher[g] = 1'b0;
			end
			else
			begin : gRest
				assign recHigher[g] = |recVec[g-1:0];
			end
		end
	endgenerate
	// One-hot winner selects the code
	wire [6:0] recWin = recVec & ~recHigher;
	reg [3:0] codeD;

	always @*
	begin
		case (recWin)
			7'h01: codeD = `EXC_OPCODE;
			7'h02: codeD = `EXC_DIVZERO;
			7'h04: codeD = `EXC_UNDEFVAR;
			7'h08: codeD = `EXC_CONV;
			7'h10: codeD = `EXC_OVERFLOW;
			7'h20: codeD = `EXC_UNDERFLOW;
			7'h40: codeD = `EXC_MAINT;
			default: codeD = `EXC_OPCODE;
		endcase
	end

	// Status word: load, then hardware flag updates
	reg [15:0] swD;
	always @*
	begin
		swD = statusWord_q;
		if (loadStatus)
		begin
			swD = (loadData & `FSW_WRITE_MASK) | (statusWord_q & ~`FSW_WRITE_MASK);
			swD[`FSW_MAINT] = kernelMode ? loadData[`FSW_MAINT] : statusWord_q[`FSW_MAINT];
			swD[`FSW_ERR] = loadData[`FSW_ERR];
		end
		if (opDone)
		begin
			swD[`FSW_NEG] = resNeg && !zeroRes;
			swD[`FSW_ZERO] = resZero || zeroRes;
			swD[`FSW_OVF] = resOverflow;
			swD[`FSW_CARRY] = convIsConversion && convCarry;
			if (anyRec)
				swD[`FSW_ERR] = 1'b1;
		end
		swD[`FSW_RSV_HI] = 1'b0;
		swD[`FSW_RSV_LO] = 1'b0;
	end

	// Status word, set flags win over a same-cycle load
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			statusWord_q <= `FSW_RESET;
		end
		else
		begin
			statusWord_q <= swD;
		end
	end

	// Precision mode mirror
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			doublePrec_q <= 1'b0;
		end
		else
		begin
			doublePrec_q <= swD[`FSW_DBL];
		end
	end

	// Integer length mirror
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			longInt_q <= 1'b0;
		end
		else
		begin
			longInt_q <= swD[`FSW_LONG];
		end
	end

	// Chop mode mirror
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			chopMode_q <= 1'b0;
		end
		else
		begin
			chopMode_q <= swD[`FSW_CHOP];
		end
	end

	// Maintenance mode mirror
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			maintMode_q <= 1'b0;
		end
		else
		begin
			maintMode_q <= swD[`FSW_MAINT];
		end
	end

	// Exception code, held until the next recorded trap
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			excCode_q <= `FEC_RESET;
		end
		else
		begin
			if (anyRec)
				excCode_q <= codeD;
		end
	end

	// Faulting instruction address
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			excAddr_q <= `FEA_RESET;
		end
		else
		begin
			if (anyRec)
				excAddr_q <= opAddr;
		end
	end

	// Interrupt request, one cycle per recorded trap while FSW_GDIS is clear
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			irqReq_q <= 1'b0;
		end
		else
		begin
			irqReq_q <= irqFire;
		end
	end

	// Shared vector for every trap
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			irqVector_q <= 9'h000;
		end
		else
		begin
			irqVector_q <= `FLOAT_VECTOR;
		end
	end

	// Exact zero on masked overflow, underflow, failed conversion or stray -0
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			forceZero_q <= 1'b0;
		end
		else
		begin
			forceZero_q <= opDone && (zeroRes
				|| (resultNegZero && !irqFire));
		end
	end

	// Stored exponent keeps the low eight bits, of the offset value only on a trapped overflow or underflow
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			storedExponent_q <= 8'h00;
		end
		else
		begin
			if (excOverflow && enOv)
				storedExponent_q <= expOvf[7:0];
			else if (excUnderflow && enUf)
				storedExponent_q <= expUdf[7:0];
			else
				storedExponent_q <= resExponent[7:0];
		end
	end

	// Undefined variable trap taken before execution
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			abortBeforeExec_q <= 1'b0;
		end
		else
		begin
			abortBeforeExec_q <= opDone && recUv && !opUndefAfterExec;
		end
	end
endmodule // float_status_exception_unit

// file: fseu_assertions.sv
// Port assertions for the float status unit
`timescale 1ns/1ps
module fseu_chk(input wire clk, rstn, loadStatus, kernelMode, opDone, excOpcode, excDivZero, irqReq_q,
	input wire [15:0] opAddr, statusWord_q, excAddr_q, input wire [3:0] excCode_q, input wire [8:0] irqVector_q);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_err; opDone && (excOpcode || excDivZero) |=> statusWord_q[15]; endproperty
	a_err: assert property (p_err) else $error("flag not set");
	property p_keep; statusWord_q[15] && !loadStatus |=> statusWord_q[15]; endproperty
	a_keep: assert property (p_keep) else $error("flag lost");
	property p_dis; statusWord_q[14] && !loadStatus |=> !irqReq_q; endproperty
	a_dis: assert property (p_dis) else $error("irq while off");
	property p_vec; irqReq_q |-> irqVector_q == 9'h0a4; endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_div; opDone && excDivZero && !excOpcode |=> excCode_q == 4'h4; endproperty
	a_div: assert property (p_div) else $error("bad code");
	property p_adr; opDone && excOpcode |=> excAddr_q == $past(opAddr); endproperty
	a_adr: assert property (p_adr) else $error("bad address");
	property p_hold; !opDone |=> $stable(excCode_q) && $stable(excAddr_q); endproperty
	a_hold: assert property (p_hold) else $error("record moved");
	property p_mm; loadStatus && !kernelMode && !opDone |=> $stable(statusWord_q[4]); endproperty
	a_mm: assert property (p_mm) else $error("user set maint");
	c_div: cover property (opDone && excDivZero);
	c_irq: cover property (irqReq_q);
	c_mm: cover property (loadStatus && kernelMode);
endmodule // fseu_chk
bind float_status_exception_unit fseu_chk i_fseu_chk(.*);

// file: fseq_model.sv
// Sequencer model finishing one instruction per command
`timescale 1ns/1ps
module fseq_model(input wire clk, go, input wire [2:0] kind, input wire [15:0] addr,
	output reg opDone, excOpcode, excDivZero, excOverflow, excUnderflow, excMaint, output reg [15:0] opAddr);
	initial {opDone, excOpcode, excDivZero, excOverflow, excUnderflow, excMaint, opAddr} = 0;
	// Idle address shows the inverse
	always @(negedge clk)
	begin
		opDone <= go;
		opAddr <= go ? addr : ~addr;
		{excUnderflow, excOverflow, excDivZero, excOpcode} <= go ? 4'h1 << (kind - 3'h1) : 4'h0;
		excMaint <= go && kind == 3'h5;
	end
endmodule // fseq_model

// file: tb.sv
// Random and corner tests of the float status unit
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("Error %0t: %h %h", $time, a, b); end end
module tb;
	reg clk = 0, rstn = 0, ld = 0, km = 0, go = 0;
	reg [2:0] kd = 0;
	reg [15:0] ldD = 0, ad = 0, ex = 0, ea = 0;
	reg [3:0] ec = 0;
	reg [31:0] rs = 32'hfe7c3a74, rr = 0;
	integer error_cnt = 0, n_checks = 0, cyc = 0, i;
	wire opDone, eO, eD, eV, eU, eM, irq, dp, li, ch, mm, fz, ab;
	wire [7:0] se;
	wire [8:0] iv;
	wire [15:0] oA, sw, eA;
	wire [3:0] eC;
	always #4 clk = ~clk;
	fseq_model i_fseq_model(.clk(clk), .go(go), .kind(kd), .addr(ad), .opDone(opDone), .excOpcode(eO),
		.excDivZero(eD), .excOverflow(eV), .excUnderflow(eU), .excMaint(eM), .opAddr(oA));
	float_status_exception_unit i_float_status_exception_unit(.clk(clk), .rstn(rstn), .loadStatus(ld),
		.loadData(ldD), .kernelMode(km), .statusWord_q(sw), .opDone(opDone), .opAddr(oA), .resNeg(rr[0]),
		.resZero(rr[1]), .resOverflow(rr[2]), .convCarry(rr[3]), .excOpcode(eO), .excDivZero(eD), .excMaint(eM),
		.excOverflow(eV), .excUnderflow(eU), .convIsConversion(1'b0), .convValue({rr, rr[0]}),
		.operandNegZero(rr[8]), .operandFromAcc(rr[5]), .opUsesUndefCheck(rr[6]), .opUndefAfterExec(rr[7]),
		.resExponent(rr[12:4]), .resultNegZero(1'b0), .forceZero_q(fz), .storedExponent_q(se),
		.abortBeforeExec_q(ab), .doublePrec_q(dp), .longInt_q(li), .chopMode_q(ch), .maintMode_q(mm),
		.excCode_q(eC), .excAddr_q(eA), .irqReq_q(irq), .irqVector_q(iv));
	function [31:0] nxt;
	begin
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		nxt = rs;
	end
	endfunction
	function [3:0] cd(input [2:0] k);
		cd = k == 1 ? 4'h2 : k == 2 ? 4'h4 : k == 3 ? 4'h8 : k == 4 ? 4'ha : 4'he;
	endfunction
	task give_verdict;
		$display("Checks %0d, errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task load(input [15:0] d, input k);
		reg [15:0] m;
		m = k ? 16'hcff0 : 16'hcfe0;
		@(negedge clk) ld = 1;
		ldD = d;
		km = k;
		rr = nxt();
		@(negedge clk) ld = 0;
		ex = ex & ~m | d & m;
		`CHK(sw[15:4], ex[15:4])
		`CHK({dp, li, ch, mm}, ex[7:4])
	endtask
	task op(input [2:0] k);
		reg rec, uv, mk;
		@(posedge clk) go <= 1;
		kd <= k;
		ad <= nxt();
		@(posedge clk) go <= 0;
		@(negedge clk) uv = ex[11] && rr[6] && rr[8] && !rr[5];
		mk = k == 3 && !ex[9] || k == 4 && !ex[10];
		rec = k == 1 || k == 2 || uv || k == 3 && ex[9] || k == 4 && ex[10] || k == 5 && ex[4];
		if (rec)
		begin
			ex[15] = 1;
			ec = (k == 1 || k == 2 || !uv) ? cd(k) : 4'hc;
			ea = ad;
		end
		`CHK(irq, rec && !ex[14])
		`CHK(sw[15:4], ex[15:4])
		`CHK(sw[3:0], {rr[0] && !mk, rr[1] || mk, rr[2], 1'b0})
		`CHK(fz, mk)
		`CHK(ab, uv && !rr[7])
		`CHK(se, rr[11:4])
		`CHK(iv, 9'h0a4)
		`CHK(eC, ec)
		`CHK(eA, ea)
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			give_verdict;
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		@(negedge clk) rstn = 1;
		`CHK(sw, 16'h0000)
		for (i = 0; i < 60; i++)
		begin
			load(nxt(), rs[20]);
			op(i % 6);
		end
		load(16'h4e00, 1);
		op(1);
		op(0);
		op(3);
		op(4);
		load(16'h0010, 0);
		load(16'h0010, 1);
		op(5);
		load(16'h0000, 0);
		give_verdict;
	end
endmodule // tb
